// ---- design/asw_host.sv ----
// Functional notes
// - Controller holds write strobe high through every read.
// - Controller sets address on the same clock edge that selects go low.
// - Data held stable around the edge that ends the write.
// - Controller does not drive lanes while device drives them.
`default_nettype none
module asw_host
   import asw_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [AW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   input wire logic [1:0] req_be,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DW-1:0] rsp_rdata,
   output logic [AW-1:0] mem_addr,
   output asw_ctrl_s mem_ctrl,
   output logic [DW-1:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic [DW-1:0] mem_data_in
);
   asw_state_e state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [1:0] be_ff;
   logic [DW-1:0] lane_mask;
   logic [1:0] be_nxt;

   // Empty byte enables are never taken, so no write opens without a byte select
   wire take = req_ready && req_valid && (req_be != BE_NONE);
   wire cnt_done = (cnt_ff == CNT_ZERO);
   // Pins follow the request in the very cycle it is taken
   assign be_nxt = take ? req_be : be_ff;
   // Unselected lanes float at the device, so mask them
   assign lane_mask = {{BYTE_W{be_ff[1]}}, {BYTE_W{be_ff[0]}}};

   // Counts round up to whole clocks, so a slower clock only adds margin
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_done ? CNT_ZERO : cnt_ff - CNT_ONE;
      case (state_ff)
         ASW_IDLE: begin
            if (take) begin
               nxt_state = req_write ? ASW_WR_PULSE : ASW_RD_SETUP;
               nxt_cnt = req_write ? CNT_W'(WRITE_CYC - 1) : CNT_W'(ACCESS_CYC);
            end
         end
         ASW_RD_SETUP: begin
            nxt_state = ASW_RD_WAIT;
         end
         ASW_RD_WAIT: begin
            if (cnt_done) begin
               nxt_state = ASW_TURN;
               nxt_cnt = CNT_W'(TURN_CYC);
            end
         end
         ASW_WR_PULSE: begin
            if (cnt_done) begin
               nxt_state = ASW_WR_END;
            end
         end
         ASW_WR_END: begin
            nxt_state = ASW_IDLE;
         end
         ASW_TURN: begin
            // Gap lets the device release its lanes before we drive them again
            if (cnt_done) begin
               nxt_state = ASW_IDLE;
            end
         end
         default: begin
            nxt_state = ASW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ASW_IDLE;
         cnt_ff <= CNT_ZERO;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Address, data and lanes latch at accept and hold to the end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_addr <= '0;
         mem_data_out <= '0;
         be_ff <= BE_NONE;
      end else if (take) begin
         mem_addr <= req_addr;
         mem_data_out <= req_wdata;
         be_ff <= req_be;
      end
   end

   // Select and byte selects assert and release together; the write strobe asserts with them but releases a cycle earlier
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_ctrl <= CTRL_IDLE;
         mem_data_oe <= 1'b0;
      end else begin
         mem_ctrl <= CTRL_IDLE;
         mem_data_oe <= 1'b0;
         if (nxt_state == ASW_RD_SETUP || nxt_state == ASW_RD_WAIT) begin
            mem_ctrl.primary_select_n <= 1'b0;
            mem_ctrl.secondary_select <= 1'b1;
            mem_ctrl.write_n <= 1'b1;
            mem_ctrl.out_drive_n <= 1'b0;
            mem_ctrl.upper_byte_sel_n <= ~be_nxt[1];
            mem_ctrl.lower_byte_sel_n <= ~be_nxt[0];
         end else if (nxt_state == ASW_WR_PULSE || nxt_state == ASW_WR_END) begin
            mem_ctrl.primary_select_n <= 1'b0;
            mem_ctrl.secondary_select <= 1'b1;
            // Output drive kept high so the device never fights us
            mem_ctrl.out_drive_n <= 1'b1;
            // Strobe rises a cycle before select, so the strobe edge ends the write
            mem_ctrl.write_n <= (nxt_state == ASW_WR_END);
            mem_ctrl.upper_byte_sel_n <= ~be_nxt[1];
            mem_ctrl.lower_byte_sel_n <= ~be_nxt[0];
            mem_data_oe <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         req_ready <= 1'b0;
      end else begin
         rsp_valid <= (state_ff == ASW_RD_WAIT) && cnt_done;
         if ((state_ff == ASW_RD_WAIT) && cnt_done) begin
            rsp_rdata <= mem_data_in & lane_mask;
         end
         req_ready <= (nxt_state == ASW_IDLE) && !take;
      end
   end

   // Pin sequencing as the memory sees it
   chk_read_no_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !mem_ctrl.out_drive_n |-> mem_ctrl.write_n && !mem_data_oe)
      else $error("write strobe low during read");
   chk_drive_only_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mem_data_oe |-> !mem_ctrl.primary_select_n && mem_ctrl.out_drive_n)
      else $error("data driven outside write");
   chk_data_hold_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(mem_ctrl.write_n) && !mem_ctrl.primary_select_n |-> mem_data_oe && $stable(mem_data_out))
      else $error("data not held at write end");
   chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !mem_ctrl.primary_select_n && !$past(mem_ctrl.primary_select_n) |-> $stable(mem_addr))
      else $error("address moved during access");
   chk_write_ends: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(mem_ctrl.write_n) |-> ##[1:8] mem_ctrl.write_n)
      else $error("write never ended");
   chk_select_pair: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mem_ctrl.primary_select_n == !mem_ctrl.secondary_select)
      else $error("select pair mismatch");
   chk_read_resp: assert property (@(posedge sys_clk) disable iff (!reset_n)
      take && !req_write |-> ##[2:8] rsp_valid)
      else $error("read response missing");
   chk_idle_float: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mem_ctrl.primary_select_n |-> !mem_data_oe && mem_ctrl.upper_byte_sel_n)
      else $error("lanes active while deselected");
   chk_write_bytes: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !mem_ctrl.write_n |-> !(mem_ctrl.upper_byte_sel_n && mem_ctrl.lower_byte_sel_n))
      else $error("write strobe with no byte select");
   chk_write_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !mem_ctrl.write_n |-> mem_data_oe && mem_ctrl.out_drive_n)
      else $error("write without our data on the lanes");
   chk_strobe_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(mem_ctrl.write_n) |-> !mem_ctrl.primary_select_n)
      else $error("write not ended by the strobe");
   chk_sel_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(mem_ctrl.primary_select_n) |-> mem_ctrl.write_n && !mem_data_oe)
      else $error("lanes still driven after deselect");
   chk_oe_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(mem_data_oe) |-> mem_ctrl.primary_select_n)
      else $error("lanes released while still selected");
   chk_addr_at_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(mem_ctrl.primary_select_n) |-> mem_addr == $past(req_addr))
      else $error("address not set when select fell");
   // Request side handshake
   chk_ready_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      req_ready |-> mem_ctrl == CTRL_IDLE && !mem_data_oe)
      else $error("ready while pins busy");
   chk_rd_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rsp_valid |=> !rsp_valid)
      else $error("read response longer than one cycle");
   chk_turn_gap: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rsp_valid |-> !req_ready)
      else $error("no turnaround after read");
   // Main scenarios
   cov_read_full: cover property (@(posedge sys_clk) disable iff (!reset_n)
      take && !req_write && req_be == 2'h3);
   cov_read_upper: cover property (@(posedge sys_clk) disable iff (!reset_n)
      take && !req_write && req_be == 2'h2);
   cov_write_low: cover property (@(posedge sys_clk) disable iff (!reset_n)
      take && req_write && req_be == 2'h1);
   cov_write_high: cover property (@(posedge sys_clk) disable iff (!reset_n)
      take && req_write && req_be == 2'h2);
   cov_resp: cover property (@(posedge sys_clk) disable iff (!reset_n)
      rsp_valid);
endmodule : asw_host
`default_nettype wire

// ---- design/asw_pkg.sv ----
`default_nettype none
package asw_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_ACCESS_NS = 45;
   localparam int T_WRITE_PULSE_NS = 35;
   localparam int T_TURN_NS = 20;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC = (T_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [1:0] BE_NONE = 2'h0;
   typedef enum logic [2:0] {
      ASW_IDLE, ASW_RD_SETUP, ASW_RD_WAIT, ASW_WR_PULSE, ASW_WR_END, ASW_TURN
   } asw_state_e;
   typedef struct packed {
      logic primary_select_n;
      logic secondary_select;
      logic write_n;
      logic out_drive_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
   } asw_ctrl_s;
   localparam asw_ctrl_s CTRL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : asw_pkg
`default_nettype wire

// ---- tb/asw_sram_model.sv ----
`default_nettype none
module asw_sram_model
   import asw_pkg::*;
(
   input wire asw_ctrl_s ctrl,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] host_data,
   input wire logic host_oe,
   output logic [DATA_W-1:0] lanes,
   output logic clash
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] word;
   logic [DATA_W-1:0] last = 16'h0000;
   logic [DATA_W-1:0] pend_data = 16'h0000;
   logic [1:0] pend_be = 2'h0;
   logic sel;
   logic wr;
   logic [1:0] bsel;
   logic [1:0] en;
   assign sel = !ctrl.primary_select_n && ctrl.secondary_select;
   assign bsel = ~{ctrl.upper_byte_sel_n, ctrl.lower_byte_sel_n};
   assign wr = sel && !ctrl.write_n && (bsel != 2'h0);
   // Floating lanes show the inverse of the last word the host drove, never a stale copy
   assign en = (sel && ctrl.write_n && !ctrl.out_drive_n) ? bsel : 2'h0;
   assign word = mem[addr];
   assign lanes[7:0] = host_oe ? host_data[7:0] : en[0] ? word[7:0] : ~last[7:0];
   assign lanes[15:8] = host_oe ? host_data[15:8] : en[1] ? word[15:8] : ~last[15:8];
   assign clash = host_oe && (en != 2'h0);
   always @(host_oe or host_data)
      if (host_oe)
         last = host_data;
   // Lanes and byte selects are tracked while the write is open
   always @(wr or bsel or lanes)
      if (wr) begin
         pend_data = lanes;
         pend_be = bsel;
      end
   // Commit at the edge that ends the write, whichever control drops first
   always @(negedge wr) begin
      if (pend_be[0])
         mem[addr][7:0] = pend_data[7:0];
      if (pend_be[1])
         mem[addr][15:8] = pend_data[15:8];
   end
endmodule : asw_sram_model
`default_nettype wire

// ---- tb/tb_async_sram_word_port.sv ----
`default_nettype none
module tb_async_sram_word_port;
   timeunit 1ns;
   timeprecision 1ns;
   import asw_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [17:0] req_addr = 18'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] req_be = 2'h0;
   logic req_ready, rsp_valid, mem_data_oe, clash;
   logic clash_seen = 1'b0;
   logic [15:0] rsp_rdata, mem_data_out, mem_data_in;
   logic [17:0] mem_addr;
   asw_ctrl_s mem_ctrl;
   int n_mismatch = 0;
   int n_compared = 0;
   asw_host i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_ctrl(mem_ctrl),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
   asw_sram_model i_mem (.ctrl(mem_ctrl), .addr(mem_addr), .host_data(mem_data_out), .host_oe(mem_data_oe),
      .lanes(mem_data_in), .clash(clash));
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (clash === 1'b1)
         clash_seen <= 1'b1;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be,
      input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge sys_clk);
      {req_valid, req_write, req_addr, req_wdata, req_be} = {1'b1, w, a, d, be};
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      req_valid = 1'b0;
      n = 0;
      while (n < 12 && !(w ? req_ready === 1'b1 : rsp_valid === 1'b1)) begin
         if (mem_ctrl.primary_select_n === 1'b0) cmp(mem_addr, a);
         if (!w) cmp(mem_ctrl.write_n, 1'b1);
         if (w && mem_ctrl.write_n === 1'b0) cmp({mem_data_oe, mem_data_out}, {1'b1, d});
         @(negedge sys_clk);
         n++;
      end
      cmp(n < 12, 1'b1);
      if (!w) cmp(rsp_rdata, exp);
   endtask : acc
   task automatic refuse_empty;
      @(negedge sys_clk);
      {req_valid, req_be} = {1'b1, 2'h0};
      // Enables of zero must never start a cycle on the pins
      repeat (4) begin
         @(negedge sys_clk);
         cmp(mem_ctrl, CTRL_IDLE);
         cmp(req_ready, 1'b1);
      end
      req_valid = 1'b0;
   endtask : refuse_empty
   task automatic print_verdict;
      $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (12) @(negedge sys_clk);
      reset_n = 1'b1;
      cmp(mem_ctrl, CTRL_IDLE);
      refuse_empty();
      acc(1'b1, 18'h3FFFF, 16'h1234, 2'h3, 16'h0000);
      acc(1'b1, 18'h3FFFF, 16'hFFAB, 2'h1, 16'h0000);
      acc(1'b1, 18'h3FFFF, 16'hCDFF, 2'h2, 16'h0000);
      acc(1'b1, 18'h00001, 16'h5A5A, 2'h3, 16'h0000);
      acc(1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'hCDAB);
      acc(1'b0, 18'h3FFFF, 16'h0000, 2'h1, 16'h00AB);
      acc(1'b0, 18'h3FFFF, 16'h0000, 2'h2, 16'hCD00);
      acc(1'b0, 18'h00001, 16'h0000, 2'h3, 16'h5A5A);
      cmp(clash_seen, 1'b0);
      print_verdict();
   end
endmodule : tb_async_sram_word_port
`default_nettype wire
